//--- dv/cod_core_monitor.sv
/* Concurrent checks on the operand-decode core ports.
   Assumes it is bound to cod_core and sees only that module's ports. */
module cod_core_monitor (
   input wire logic        i_core_clk,     // Core clock
   input wire logic        i_reset,        // Synchronous reset
   input wire logic [7:0]  i_mem_rdata,    // Read data
   input wire logic [15:0] o_mem_addr,     // Bus address
   input wire logic        o_mem_rd,       // Read cycle
   input wire logic        o_mem_wr,       // Write cycle
   input wire logic [7:0]  o_mem_wdata,    // Write data
   input wire logic [7:0]  o_flags,        // Flags
   input wire logic [7:0]  o_acc,          // Accumulator
   input wire logic [15:0] o_hx,           // Pointer pair
   input wire logic [15:0] o_sp,           // Stack pointer
   input wire logic [15:0] o_pc,           // Fetch address
   input wire logic        o_opcode_fetch, // Opcode cycle
   input wire logic        o_bad_opcode    // Undecoded pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   // ----------------------------------------
   // Spare flag bits, then checks keyed on the opcode byte fetched
   // ----------------------------------------
   chk_flag_spare: assert property (o_flags[6:5] == 2'b00)
      else $error("spare flag bits set");
   chk_stack_adj: assert property (o_opcode_fetch && i_mem_rdata == 8'hA7 ##1 1'b1 |=> o_opcode_fetch
      && o_sp == $past(o_sp, 2) + {{8{$past(i_mem_rdata[7])}}, $past(i_mem_rdata)}) else $error("stack adjust wrong");
   chk_adj_flags: assert property (o_opcode_fetch && i_mem_rdata == 8'hA7 |-> ##2 o_flags == $past(o_flags, 2))
      else $error("stack adjust changed flags");
   chk_branch_dest: assert property (o_opcode_fetch && i_mem_rdata == 8'h24 && !o_flags[0] |-> ##3
      (o_opcode_fetch && o_pc == $past(o_pc, 3) + 16'h0002 + {{8{$past(i_mem_rdata[7], 2)}}, $past(i_mem_rdata, 2)}))
      else $error("branch target or timing wrong");
   chk_zero_page: assert property (o_opcode_fetch && i_mem_rdata == 8'hB7 |-> ##2
      (o_mem_wr && o_mem_addr == {8'h00, $past(i_mem_rdata)})) else $error("direct store address wrong");
   chk_pair_order: assert property (o_opcode_fetch && i_mem_rdata == 8'h96 |-> ##3 (o_mem_wr
      && o_mem_addr == {$past(i_mem_rdata, 2), $past(i_mem_rdata)} && o_mem_wdata == o_hx[15:8]) ##1
      (o_mem_wr && o_mem_addr == $past(o_mem_addr) + 16'h0001 && o_mem_wdata == o_hx[7:0])) else $error("pair store order");
   chk_full_addr: assert property (o_opcode_fetch && i_mem_rdata == 8'hC6 |-> ##3
      (o_mem_rd && o_mem_addr == {$past(i_mem_rdata, 2), $past(i_mem_rdata)})) else $error("full address wrong");
   chk_copy_step: assert property (o_opcode_fetch && i_mem_rdata == 8'h7E |-> ##2 (o_mem_rd && o_mem_addr == o_hx)
      ##1 (o_mem_wr && o_mem_addr == {8'h00, $past(i_mem_rdata, 2)}) ##1 (o_hx == $past(o_hx, 2) + 16'h0001))
      else $error("copy with step wrong");
endmodule
bind cod_core cod_core_monitor i_mon (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_mem_rdata(i_mem_rdata),
   .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_flags(o_flags),
   .o_acc(o_acc), .o_hx(o_hx), .o_sp(o_sp), .o_pc(o_pc), .o_opcode_fetch(o_opcode_fetch), .o_bad_opcode(o_bad_opcode));

//--- dv/cod_core_tb.sv
/* Self-checking bench for the operand-decode core running a short program.
   Assumes the memory model answers every bus cycle without wait. */
module cod_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_core_clk = 1'b0;
   logic i_reset = 1'b1;
   wire logic [7:0] rdata;
   wire logic [7:0] wdata;
   wire logic [7:0] o_flags;
   wire logic [7:0] o_acc;
   wire logic [15:0] addr;
   wire logic [15:0] o_hx;
   wire logic [15:0] o_sp;
   wire logic [15:0] o_pc;
   wire logic rd;
   wire logic wr;
   wire logic o_opcode_fetch;
   wire logic o_bad_opcode;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [7:0] prog [0:40] = '{8'h45, 8'h12, 8'h34, 8'hA6, 8'h5A, 8'hA7, 8'hFE, 8'hAF, 8'h80, 8'hB7, 8'h40,
      8'h96, 8'h02, 8'h00, 8'hC6, 8'h02, 8'h01, 8'hE6, 8'hF0, 8'hD6, 8'hFF, 8'h00, 8'h9E, 8'hE6, 8'h03,
      8'h24, 8'h02, 8'hA6, 8'hEE, 8'h7E, 8'h50, 8'hAB, 8'h5F, 8'h61, 8'h10, 8'h02, 8'hA6, 8'hEE, 8'h01,
      8'h24, 8'hFD};
   cod_core i_cod_core (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_mem_rdata(rdata), .o_mem_addr(addr),
      .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_wdata(wdata), .o_flags(o_flags), .o_acc(o_acc), .o_hx(o_hx),
      .o_sp(o_sp), .o_pc(o_pc), .o_opcode_fetch(o_opcode_fetch), .o_bad_opcode(o_bad_opcode));
   cod_mem_model i_cod_mem_model (.i_core_clk(i_core_clk), .i_addr(addr), .i_rd(rd), .i_wr(wr),
      .i_wdata(wdata), .o_rdata(rdata));
   initial begin
      forever #25 i_core_clk = ~i_core_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("mismatches %0d of %0d comparisons", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Bounded wait for the opcode fetch at a given address
   task automatic wait_fetch(input logic [15:0] a);
      int i;
      for (i = 0; i < 60; i++) begin
         @(posedge i_core_clk);
         #1;
         if (o_opcode_fetch === 1'b1 && o_pc === a) return;
      end
      n_mismatch++;
      $display("mismatch at %0t: no fetch at %h", $time, a);
      check(o_pc, a);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_literal();
      wait_fetch(16'h0003);
      check(o_hx, 16'h1234);
      wait_fetch(16'h0005);
      check({8'h00, o_acc}, 16'h005A);
   endtask
   task automatic t_adjust();
      repeat (2) @(posedge i_core_clk);
      #1;
      check({15'h0000, o_opcode_fetch}, 16'h0001);
      check(o_pc, 16'h0007);
      check(o_sp, 16'h00FD);
      wait_fetch(16'h0009);
      check(o_hx, 16'h11B4);
      check({8'h00, o_flags}, 16'h0008);
   endtask
   task automatic t_store();
      wait_fetch(16'h000E);
      check({8'h00, i_cod_mem_model.mem[16'h0040]}, 16'h005A);
      check({i_cod_mem_model.mem[16'h0200], i_cod_mem_model.mem[16'h0201]}, 16'h11B4);
      wait_fetch(16'h0011);
      check({8'h00, o_acc}, 16'h00B4);
      check({8'h00, o_flags}, 16'h000C);
   endtask
   task automatic t_offsets();
      wait_fetch(16'h0013);
      check({8'h00, o_acc}, 16'h0077);
      wait_fetch(16'h0016);
      check({8'h00, o_acc}, 16'h003C);
      wait_fetch(16'h0019);
      check({8'h00, o_acc}, 16'h0021);
   endtask
   task automatic t_branch();
      repeat (3) @(posedge i_core_clk);
      #1;
      check(o_pc, 16'h001D);
      check({8'h00, o_flags}, 16'h0008);
   endtask
   task automatic t_copy();
      wait_fetch(16'h001F);
      check({8'h00, i_cod_mem_model.mem[16'h0050]}, 16'h0099);
      check(o_hx, 16'h11B5);
      wait_fetch(16'h0021);
      check({8'h00, o_acc}, 16'h0080);
      check({8'h00, o_flags}, 16'h009C);
      wait_fetch(16'h0026);
      check(o_hx, 16'h11B6);
      check({8'h00, o_acc}, 16'h0080);
      check({8'h00, o_flags}, 16'h009C);
      @(posedge i_core_clk);
      #1;
      check({o_bad_opcode, o_pc[14:0]}, 16'h8027);
      check(o_hx, 16'h11B6);
      repeat (2) wait_fetch(16'h0026);
   endtask
   initial begin
      foreach (prog[k]) i_cod_mem_model.mem[k] = prog[k];
      i_cod_mem_model.mem[16'h12A4] = 8'h77;
      i_cod_mem_model.mem[16'h10B4] = 8'h3C;
      i_cod_mem_model.mem[16'h0100] = 8'h21;
      i_cod_mem_model.mem[16'h11B4] = 8'h99;
      i_cod_mem_model.mem[16'h11C5] = 8'h80;
      repeat (2) @(posedge i_core_clk);
      i_reset <= 1'b0;
      t_literal();
      t_adjust();
      t_store();
      t_offsets();
      t_branch();
      t_copy();
      final_report();
   end
   initial begin
      #(2000 * 50);
      n_mismatch++;
      final_report();
   end
endmodule

//--- dv/cod_mem_model.sv
/* Zero-wait-state memory on the core's bus.
   Assumes one bus cycle per clock and a combinational read. */
module cod_mem_model (
   input  wire logic        i_core_clk, // Core clock
   input  wire logic [15:0] i_addr,     // Bus address
   input  wire logic        i_rd,       // Read cycle
   input  wire logic        i_wr,       // Write cycle
   input  wire logic [7:0]  i_wdata,    // Write data
   output wire logic [7:0]  o_rdata     // Read data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:65535];
   logic [7:0] last_q;
   // Idle bus shows the inverse of the last byte, so stale data never matches
   assign o_rdata = i_rd ? mem[i_addr] : ~last_q;
   always @(posedge i_core_clk) begin
      if (i_wr) begin
         mem[i_addr] <= i_wdata;
      end
      if (i_rd) begin
         last_q <= mem[i_addr];
      end
   end
endmodule

//--- inc/cod_consts.vh
/*
 * Constants for the operand-decode core: flag positions, reset values,
 * opcode encodings and addressing-mode codes.
 * Assumes it is included by bare name from every design file that needs it.
 */
`ifndef COD_CONSTS_VH
`define COD_CONSTS_VH

// ---------------------------------------------
// Condition flag bit positions
// ---------------------------------------------
`define COD_FLG_V 7
`define COD_FLG_H 4
`define COD_FLG_I 3
`define COD_FLG_N 2
`define COD_FLG_Z 1
`define COD_FLG_C 0

// ---------------------------------------------
// Reset values
// ---------------------------------------------
`define COD_FLAGS_RST 8'h08
`define COD_SP_RST    16'h00FF
`define COD_PC_RST    16'h0000

// ---------------------------------------------
// Opcodes decoded as a whole byte
// ---------------------------------------------
`define COD_OP_SPADJ    8'hA7
`define COD_OP_HXADJ    8'hAF
`define COD_OP_BRNC     8'h24
`define COD_OP_CBR_PS   8'h71
`define COD_OP_CBR_OPS  8'h61
`define COD_OP_COPY_PS  8'h7E
`define COD_OP_LDHX_LIT 8'h45
`define COD_OP_LDHX_ABS 8'h32
`define COD_OP_STHX_ABS 8'h96
`define COD_OP_PREFIX   8'h9E

// ---------------------------------------------
// Low-nibble operation codes of the mode rows
// ---------------------------------------------
`define COD_LO_LDA 4'h6
`define COD_LO_STA 4'h7
`define COD_LO_ADD 4'hB

// ---------------------------------------------
// Addressing-mode codes
// ---------------------------------------------
`define COD_M_LIT 3'h0
`define COD_M_DIR 3'h1
`define COD_M_ABS 3'h2
`define COD_M_IX  3'h3
`define COD_M_IXS 3'h4
`define COD_M_IXL 3'h5
`define COD_M_SPS 3'h6
`define COD_M_SPL 3'h7

`endif

//--- src/cod_core.v
/*
 * Operand-decode core: fetches instructions byte by byte over a simple
 * memory bus, forms effective addresses and executes a sample subset
 * (load and add in every mode, store in every mode but literal, pointer-pair load and store,
 * stack and pointer adjust, branch on no carry, compare-and-branch and
 * byte copy with post-step).
 * Assumes memory answers combinationally: i_mem_rdata is valid in the
 * same cycle that o_mem_addr and o_mem_rd show. One bus cycle per clock.
 */
// Notes on behaviour
// - Flags hold overflow in bit 7 and half carry in bit 4.
// - Flags hold mask bit 3, negative 2, zero 1, carry 0 from result bit 7.
// - A 16-bit memory value is high byte at address, low byte next.
// - Zero-page mode: operand is low address byte, high byte is zero.
// - Relative branch adds sign-extended offset to address after the branch.
// - Long pointer offset adds modulo 64K, signed or unsigned alike.
// - Pointer post-step with no offset exists only for compare-branch and copy.
// - Short pointer offset is unsigned, zero-extended before adding.
// - Pointer modes add no offset, a short or a long offset to the pointer pair.
// - Stack modes add a short or long offset to the stack pointer.
// - Full address mode takes high byte first, low byte second.
// - Long offsets take upper byte first, lower byte second.
// - Long literal takes high data byte first, low byte next.
// - Literal mode carries eight or sixteen bits per instruction.
// - Stack adjust op adds signed literal to SP in two cycles, flags kept.
// - Pointer adjust op adds signed literal to pointer pair, flags kept.
// - Branch on no carry branches when carry is 0, three cycles, flags kept.
// - Short-offset post-step form increments the pointer pair after the fetch.
`include "cod_consts.vh"

module cod_core (
   input  wire        i_core_clk,     // Core clock, 20 MHz
   input  wire        i_reset,        // Synchronous reset, active high
   input  wire [7:0]  i_mem_rdata,    // Read data for the current bus cycle
   output wire [15:0] o_mem_addr,     // Bus address
   output wire        o_mem_rd,       // Read cycle
   output wire        o_mem_wr,       // Write cycle
   output wire [7:0]  o_mem_wdata,    // Write data
   output wire [7:0]  o_flags,        // Condition flags register
   output wire [7:0]  o_acc,          // Accumulator
   output wire [15:0] o_hx,           // Pointer register pair
   output wire [15:0] o_sp,           // Stack pointer
   output wire [15:0] o_pc,           // Address of byte being fetched
   output wire        o_opcode_fetch, // Cycle fetches a first opcode byte
   output wire        o_bad_opcode    // Pulse: opcode not decoded
);

   // ---------------------------------------------
   // Encodings
   // ---------------------------------------------
   localparam [2:0] ST_OP   = 3'h0;
   localparam [2:0] ST_B1   = 3'h1;
   localparam [2:0] ST_B2   = 3'h2;
   localparam [2:0] ST_RD1  = 3'h3;
   localparam [2:0] ST_RD2  = 3'h4;
   localparam [2:0] ST_WR1  = 3'h5;
   localparam [2:0] ST_WR2  = 3'h6;
   localparam [2:0] ST_IDLE = 3'h7;

   localparam [3:0] K_BAD   = 4'h0;
   localparam [3:0] K_LDA   = 4'h1;
   localparam [3:0] K_STA   = 4'h2;
   localparam [3:0] K_ADD   = 4'h3;
   localparam [3:0] K_SPADJ = 4'h4;
   localparam [3:0] K_HXADJ = 4'h5;
   localparam [3:0] K_BRNC  = 4'h6;
   localparam [3:0] K_CBR   = 4'h7;
   localparam [3:0] K_COPY  = 4'h8;
   localparam [3:0] K_LDHX  = 4'h9;
   localparam [3:0] K_STHX  = 4'hA;

   // ---------------------------------------------
   // Registers
   // ---------------------------------------------
   reg [2:0]  state_q;
   reg [7:0]  op_q;
   reg        pre_q;
   reg [7:0]  b1_q;
   reg [7:0]  b2_q;
   reg [15:0] pc_q;
   reg [15:0] addr_q;
   reg        rd_q;
   reg        wr_q;
   reg [7:0]  wdata_q;
   reg [7:0]  flags_q;
   reg [7:0]  acc_q;
   reg [15:0] hx_q;
   reg [15:0] sp_q;
   reg        sync_q;
   reg        bad_q;

   // ---------------------------------------------
   // Decode functions
   // ---------------------------------------------
   function [3:0] f_kind;
      input [7:0] op;
      input       pre;
      begin
         f_kind = K_BAD;
         if (!pre) begin
            case (op)
               `COD_OP_SPADJ:    f_kind = K_SPADJ;
               `COD_OP_HXADJ:    f_kind = K_HXADJ;
               `COD_OP_BRNC:     f_kind = K_BRNC;
               `COD_OP_CBR_PS:   f_kind = K_CBR;
               `COD_OP_CBR_OPS:  f_kind = K_CBR;
               `COD_OP_COPY_PS:  f_kind = K_COPY;
               `COD_OP_LDHX_LIT: f_kind = K_LDHX;
               `COD_OP_LDHX_ABS: f_kind = K_LDHX;
               `COD_OP_STHX_ABS: f_kind = K_STHX;
               default:           f_kind = K_BAD;
            endcase
         end
         // Prefixed rows exist only for the two stack modes
         if (f_kind == K_BAD && op[7:4] >= 4'hA &&
             (!pre || op[7:4] == 4'hD || op[7:4] == 4'hE)) begin
            case (op[3:0])
               `COD_LO_LDA: f_kind = K_LDA;
               `COD_LO_STA: f_kind = (op[7:4] == 4'hA) ? K_BAD : K_STA;
               `COD_LO_ADD: f_kind = K_ADD;
               default:     f_kind = K_BAD;
            endcase
         end
      end
   endfunction

   function [2:0] f_mode;
      input [7:0] op;
      input       pre;
      begin
         case (op)
            `COD_OP_LDHX_LIT: f_mode = `COD_M_LIT;
            `COD_OP_LDHX_ABS: f_mode = `COD_M_ABS;
            `COD_OP_STHX_ABS: f_mode = `COD_M_ABS;
            `COD_OP_CBR_PS:   f_mode = `COD_M_IX;
            `COD_OP_COPY_PS:  f_mode = `COD_M_IX;
            `COD_OP_CBR_OPS:  f_mode = `COD_M_IXS;
            default: begin
               case (op[7:4])
                  4'hB:    f_mode = `COD_M_DIR;
                  4'hC:    f_mode = `COD_M_ABS;
                  4'hD:    f_mode = pre ? `COD_M_SPL : `COD_M_IXL;
                  4'hE:    f_mode = pre ? `COD_M_SPS : `COD_M_IXS;
                  4'hF:    f_mode = `COD_M_IX;
                  default: f_mode = `COD_M_LIT;
               endcase
            end
         endcase
      end
   endfunction

   // Number of operand bytes after the opcode
   function [1:0] f_nopr;
      input [7:0] op;
      input [2:0] mode;
      begin
         if (op == `COD_OP_LDHX_LIT || op == `COD_OP_CBR_OPS)
            f_nopr = 2'h2;
         else if (op == `COD_OP_CBR_PS || op == `COD_OP_COPY_PS)
            f_nopr = 2'h1;
         else begin
            case (mode)
               `COD_M_IX:  f_nopr = 2'h0;
               `COD_M_ABS: f_nopr = 2'h2;
               `COD_M_IXL: f_nopr = 2'h2;
               `COD_M_SPL: f_nopr = 2'h2;
               default:    f_nopr = 2'h1;
            endcase
         end
      end
   endfunction

   function [15:0] f_sext;
      input [7:0] v;
      begin
         f_sext = {{8{v[7]}}, v};
      end
   endfunction

   function [15:0] f_rel;
      input [15:0] pc_next;
      input [7:0]  rr;
      begin
         f_rel = pc_next + f_sext(rr);
      end
   endfunction

   // Load-style flags: overflow cleared, N and Z from value, rest kept
   function [7:0] f_ld_flags;
      input [7:0] fl;
      input       neg;
      input       zero;
      begin
         f_ld_flags = fl;
         f_ld_flags[`COD_FLG_V] = 1'b0;
         f_ld_flags[`COD_FLG_N] = neg;
         f_ld_flags[`COD_FLG_Z] = zero;
      end
   endfunction

   function [7:0] f_add_flags;
      input [7:0] fl;
      input [7:0] a;
      input [7:0] m;
      reg   [8:0] s;
      reg   [4:0] h;
      begin
         s = {1'b0, a} + {1'b0, m};
         h = {1'b0, a[3:0]} + {1'b0, m[3:0]};
         f_add_flags = fl;
         f_add_flags[`COD_FLG_V] = (a[7] & m[7] & ~s[7]) | (~a[7] & ~m[7] & s[7]);
         f_add_flags[`COD_FLG_H] = h[4];
         f_add_flags[`COD_FLG_N] = s[7];
         f_add_flags[`COD_FLG_Z] = (s[7:0] == 8'h00);
         f_add_flags[`COD_FLG_C] = s[8];
      end
   endfunction

   // ---------------------------------------------
   // Decode of the current instruction
   // ---------------------------------------------
   wire [7:0]  op_cur   = (state_q == ST_OP) ? i_mem_rdata : op_q;
   wire [3:0]  kind_w   = f_kind(op_cur, pre_q);
   wire [2:0]  mode_w   = f_mode(op_cur, pre_q);
   wire [1:0]  nopr_w   = f_nopr(op_cur, mode_w);
   wire [15:0] pc_next  = pc_q + 16'h0001;
   wire        is_pre   = (state_q == ST_OP) && (i_mem_rdata == `COD_OP_PREFIX) && !pre_q;
   wire        last_w   = ((state_q == ST_OP) && !is_pre && kind_w != K_BAD && nopr_w == 2'h0) ||
                          ((state_q == ST_B1) && nopr_w == 2'h1) || (state_q == ST_B2);
   // The short-offset post-step form keeps its offset in the first byte
   wire        off_b1   = (op_q == `COD_OP_CBR_OPS) && (state_q == ST_B2);
   wire [7:0]  opr_lo   = off_b1 ? b1_q : i_mem_rdata;
   wire [15:0] ea_w;
   wire [8:0]  add_sum  = {1'b0, acc_q} + {1'b0, i_mem_rdata};

   cod_ea_unit u_ea (
      .i_mode   (mode_w),
      .i_hx     (hx_q),
      .i_sp     (sp_q),
      .i_opr_hi (b1_q),
      .i_opr_lo (opr_lo),
      .o_ea     (ea_w)
   );

   // ---------------------------------------------
   // Sequencer and datapath
   // ---------------------------------------------
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         state_q <= ST_OP;
         op_q    <= 8'h00;
         pre_q   <= 1'b0;
         b1_q    <= 8'h00;
         b2_q    <= 8'h00;
         pc_q    <= `COD_PC_RST;
         addr_q  <= `COD_PC_RST;
         rd_q    <= 1'b1;
         wr_q    <= 1'b0;
         wdata_q <= 8'h00;
         flags_q <= `COD_FLAGS_RST;
         acc_q   <= 8'h00;
         hx_q    <= 16'h0000;
         sp_q    <= `COD_SP_RST;
         sync_q  <= 1'b1;
         bad_q   <= 1'b0;
      end else begin
         sync_q <= 1'b0;
         bad_q  <= 1'b0;
         case (state_q)
            ST_OP: begin
               pc_q   <= pc_next;
               addr_q <= pc_next;
               op_q   <= i_mem_rdata;
               if (is_pre) begin
                  pre_q <= 1'b1;
               end else if (kind_w == K_BAD) begin
                  // Undecoded opcodes act as a one-cycle no-op
                  bad_q  <= 1'b1;
                  pre_q  <= 1'b0;
                  sync_q <= 1'b1;
               end else begin
                  state_q <= ST_B1;
               end
            end
            ST_B1: begin
               b1_q    <= i_mem_rdata;
               pc_q    <= pc_next;
               addr_q  <= pc_next;
               state_q <= ST_B2;
            end
            ST_B2: begin
               state_q <= ST_OP;
            end
            ST_RD1: begin
               state_q <= ST_OP;
               case (op_q[3:0] == `COD_LO_ADD ? K_ADD : f_kind(op_q, pre_q))
                  K_LDA: begin
                     acc_q   <= i_mem_rdata;
                     flags_q <= f_ld_flags(flags_q, i_mem_rdata[7], i_mem_rdata == 8'h00);
                  end
                  K_ADD: begin
                     acc_q   <= add_sum[7:0];
                     flags_q <= f_add_flags(flags_q, acc_q, i_mem_rdata);
                  end
                  K_LDHX: begin
                     hx_q[15:8] <= i_mem_rdata;
                     addr_q     <= addr_q + 16'h0001;
                     state_q    <= ST_RD2;
                  end
                  K_CBR: begin
                     hx_q    <= hx_q + 16'h0001;
                     pc_q    <= (acc_q == i_mem_rdata) ? f_rel(pc_next, b2_q) : pc_next;
                     rd_q    <= 1'b0;
                     state_q <= ST_IDLE;
                  end
                  K_COPY: begin
                     hx_q    <= hx_q + 16'h0001;
                     addr_q  <= {8'h00, b2_q};
                     wdata_q <= i_mem_rdata;
                     flags_q <= f_ld_flags(flags_q, i_mem_rdata[7], i_mem_rdata == 8'h00);
                     rd_q    <= 1'b0;
                     wr_q    <= 1'b1;
                     state_q <= ST_WR2;
                  end
                  default: state_q <= ST_OP;
               endcase
            end
            ST_RD2: begin
               hx_q[7:0] <= i_mem_rdata;
               flags_q   <= f_ld_flags(flags_q, hx_q[15], {hx_q[15:8], i_mem_rdata} == 16'h0000);
               state_q   <= ST_OP;
            end
            ST_WR1: begin
               // Pointer-pair store: low byte goes to the next address
               addr_q  <= addr_q + 16'h0001;
               wdata_q <= hx_q[7:0];
               state_q <= ST_WR2;
            end
            ST_WR2: begin
               state_q <= ST_OP;
            end
            ST_IDLE: begin
               addr_q  <= pc_q;
               rd_q    <= 1'b1;
               sync_q  <= 1'b1;
               pre_q   <= 1'b0;
               state_q <= ST_OP;
            end
            default: state_q <= ST_OP;
         endcase

         // Instruction ends or data phase starts on its last operand byte
         if (last_w) begin
            pc_q    <= pc_next;
            addr_q  <= pc_next;
            rd_q    <= 1'b1;
            wr_q    <= 1'b0;
            sync_q  <= 1'b1;
            pre_q   <= 1'b0;
            state_q <= ST_OP;
            b2_q    <= i_mem_rdata;
            if (mode_w != `COD_M_LIT || kind_w == K_CBR || kind_w == K_COPY) begin
               // Memory operand: hold the last byte address until the data phase ends
               pc_q   <= pc_q;
               addr_q <= ea_w;
               sync_q <= 1'b0;
               pre_q  <= pre_q;
               case (kind_w)
                  K_STA: begin
                     rd_q    <= 1'b0;
                     wr_q    <= 1'b1;
                     wdata_q <= acc_q;
                     flags_q <= f_ld_flags(flags_q, acc_q[7], acc_q == 8'h00);
                     state_q <= ST_WR2;
                  end
                  K_STHX: begin
                     rd_q    <= 1'b0;
                     wr_q    <= 1'b1;
                     wdata_q <= hx_q[15:8];
                     flags_q <= f_ld_flags(flags_q, hx_q[15], hx_q == 16'h0000);
                     state_q <= ST_WR1;
                  end
                  default: state_q <= ST_RD1;
               endcase
            end else begin
               case (kind_w)
                  K_SPADJ: sp_q <= sp_q + f_sext(i_mem_rdata);
                  K_HXADJ: hx_q <= hx_q + f_sext(i_mem_rdata);
                  K_LDA: begin
                     acc_q   <= i_mem_rdata;
                     flags_q <= f_ld_flags(flags_q, i_mem_rdata[7], i_mem_rdata == 8'h00);
                  end
                  K_ADD: begin
                     acc_q   <= add_sum[7:0];
                     flags_q <= f_add_flags(flags_q, acc_q, i_mem_rdata);
                  end
                  K_LDHX: begin
                     hx_q    <= {b1_q, i_mem_rdata};
                     flags_q <= f_ld_flags(flags_q, b1_q[7], {b1_q, i_mem_rdata} == 16'h0000);
                  end
                  K_BRNC: begin
                     // One free cycle makes the three; taken or not
                     pc_q    <= flags_q[`COD_FLG_C] ? pc_next : f_rel(pc_next, i_mem_rdata);
                     rd_q    <= 1'b0;
                     sync_q  <= 1'b0;
                     state_q <= ST_IDLE;
                  end
                  default: state_q <= ST_OP;
               endcase
            end
         end else if (state_q == ST_RD2 || (state_q == ST_WR2)) begin
            pc_q    <= pc_next;
            addr_q  <= pc_next;
            rd_q    <= 1'b1;
            wr_q    <= 1'b0;
            sync_q  <= 1'b1;
            pre_q   <= 1'b0;
         end else if (state_q == ST_RD1 && (op_q[3:0] == `COD_LO_LDA || op_q[3:0] == `COD_LO_ADD) &&
                      op_q != `COD_OP_COPY_PS) begin
            pc_q    <= pc_next;
            addr_q  <= pc_next;
            sync_q  <= 1'b1;
            pre_q   <= 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign o_mem_addr     = addr_q;
   assign o_mem_rd       = rd_q;
   assign o_mem_wr       = wr_q;
   assign o_mem_wdata    = wdata_q;
   assign o_flags        = flags_q;
   assign o_acc          = acc_q;
   assign o_hx           = hx_q;
   assign o_sp           = sp_q;
   assign o_pc           = pc_q;
   assign o_opcode_fetch = sync_q;
   assign o_bad_opcode   = bad_q;

endmodule

//--- src/cod_ea_unit.v
/*
 * Effective-address former for the operand-decode core.
 * Assumes operand bytes are presented in instruction order: i_opr_hi is
 * the first operand byte, i_opr_lo the one after it (or the only one).
 */
`include "cod_consts.vh"

module cod_ea_unit (
   input  wire [2:0]  i_mode,    // Addressing mode code
   input  wire [15:0] i_hx,      // Pointer register pair
   input  wire [15:0] i_sp,      // Stack pointer
   input  wire [7:0]  i_opr_hi,  // First operand byte
   input  wire [7:0]  i_opr_lo,  // Last or only operand byte
   output reg  [15:0] o_ea       // Effective address or literal
);

   // ---------------------------------------------
   // Address formation
   // ---------------------------------------------
   // All sums are cut to 16 bits, so the long offset wraps either way
   always @* begin
      case (i_mode)
         `COD_M_DIR: o_ea = {8'h00, i_opr_lo};
         `COD_M_ABS: o_ea = {i_opr_hi, i_opr_lo};
         `COD_M_IX:  o_ea = i_hx;
         `COD_M_IXS: o_ea = i_hx + {8'h00, i_opr_lo};
         `COD_M_IXL: o_ea = i_hx + {i_opr_hi, i_opr_lo};
         `COD_M_SPS: o_ea = i_sp + {8'h00, i_opr_lo};
         `COD_M_SPL: o_ea = i_sp + {i_opr_hi, i_opr_lo};
         default:    o_ea = {i_opr_hi, i_opr_lo};
      endcase
   end

endmodule
